// ---- design/ssr_sram.sv ----
/*
 * ssr_sram: synchronous 16K x 4 static RAM with input registers and a
 * choice of transparent output latch or pipelined output register.
 * Assumes a controller driving all inputs synchronous to ref_clk, and a
 * board or bench that resolves rd_data from rd_data_oe.
 */
`timescale 1ns/1ns
`default_nettype none
module ssr_sram
    import ssr_pkg::*;
#(
    parameter logic OUT_MODE = ssr_pkg::OUT_LATCH,
    parameter int ADDR_BITS = ssr_pkg::ADDR_W,
    parameter int DATA_BITS = ssr_pkg::DATA_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // access inputs from the controller
    input wire logic [ADDR_BITS-1:0] word_addr,
    input wire logic [DATA_BITS-1:0] wr_data,
    input wire logic wr_en_n,
    input wire logic sel_n,
    // read data output, separate from the write data
    output logic [DATA_BITS-1:0] rd_data,
    output logic rd_data_oe
);
    import ssr_pkg::*;

    // refuse widths that the array or the output stage cannot serve
    if (ADDR_BITS < 1 || ADDR_BITS > 20 || DATA_BITS < 1)
    begin : g_bad_width
        $error("ssr_sram: unsupported width");
    end

    // input registers
    logic [ADDR_BITS-1:0] addr_r, addr_nxt;
    logic [DATA_BITS-1:0] din_r, din_nxt;
    logic wen_n_r, wen_n_nxt;
    logic sel_n_r, sel_n_nxt;
    logic [DATA_BITS-1:0] arr_word;
    ssr_op_t op;

    // capture every input without inversion
    always_comb
    begin
        addr_nxt = word_addr;
        din_nxt = wr_data;
        wen_n_nxt = wr_en_n;
        sel_n_nxt = sel_n;
    end

    // input registers; start deselected after reset
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_r <= '0;
            din_r <= DATA_RST;
            wen_n_r <= 1'b1;
            sel_n_r <= 1'b1;
        end
        else
        begin
            addr_r <= addr_nxt;
            din_r <= din_nxt;
            wen_n_r <= wen_n_nxt;
            sel_n_r <= sel_n_nxt;
        end
    end

    // cycle decode from the sampled select and write enable
    always_comb
    begin
        if (sel_n_r)
            op = SSR_OP_IDLE;
        else if (wen_n_r)
            op = SSR_OP_READ;
        else
            op = SSR_OP_WRITE;
    end

    // shared storage, 2**14 words of 4 bits
    ssr_array #(
        .ADDR_W(ADDR_BITS),
        .DATA_W(DATA_BITS)
    ) u_array (
        .ref_clk(ref_clk),
        .wr_en(op == SSR_OP_WRITE),
        .wr_addr(addr_r),
        .wr_word(din_r),
        .rd_addr(addr_r),
        .rd_word(arr_word)
    );

    // output stage selected at design time
    generate
        if (OUT_MODE == OUT_LATCH)
        begin : g_latch
            // low-phase update: sample on falling edge, hold whole high
            logic [DATA_BITS-1:0] q_r, q_nxt;
            logic oe_r, oe_nxt;

            always_comb
            begin
                q_nxt = q_r;
                oe_nxt = 1'b0;
                case (op)
                    SSR_OP_READ:
                    begin
                        q_nxt = arr_word;
                        oe_nxt = 1'b1;
                    end
                    SSR_OP_WRITE: oe_nxt = 1'b0;
                    SSR_OP_IDLE: oe_nxt = 1'b0;
                    default: oe_nxt = 1'b0;
                endcase
            end

            // only the falling edge and the asynchronous reset move the outputs
            always_ff @(negedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    q_r <= DATA_RST;
                    oe_r <= 1'b0;
                end
                else
                begin
                    q_r <= q_nxt;
                    oe_r <= oe_nxt;
                end
            end

            assign rd_data = q_r;
            assign rd_data_oe = oe_r;

            // value held at the rising edge, for the high-phase check
            logic [DATA_BITS-1:0] rise_q_r;

            always_ff @(posedge ref_clk)
            begin
                rise_q_r <= q_r;
            end

            hold_high_a: assert property (@(negedge ref_clk)
                disable iff (!rst_n)
                q_r == rise_q_r)
                else $error("latch output moved at a rising edge");
            read_follow_a: assert property (@(negedge ref_clk)
                disable iff (!rst_n)
                (op == SSR_OP_READ) |=>
                (rd_data_oe && rd_data == $past(arr_word)))
                else $error("read data not shown in low phase");
            write_float_a: assert property (@(negedge ref_clk)
                disable iff (!rst_n)
                (op != SSR_OP_READ) |=> !rd_data_oe)
                else $error("outputs driven outside a read");
            keep_data_a: assert property (@(negedge ref_clk)
                disable iff (!rst_n)
                (op != SSR_OP_READ) |=> $stable(rd_data))
                else $error("latched data changed without read");
            c_latch_read: cover property (@(negedge ref_clk)
                disable iff (!rst_n) op == SSR_OP_READ);
        end
        else
        begin : g_reg
            // pipelined register: last valid read appears at next edge
            logic [DATA_BITS-1:0] q_r, q_nxt;
            logic oe_r, oe_nxt;

            always_comb
            begin
                q_nxt = q_r;
                oe_nxt = 1'b0;
                case (op)
                    SSR_OP_READ:
                    begin
                        q_nxt = arr_word;
                        oe_nxt = 1'b1;
                    end
                    SSR_OP_WRITE: oe_nxt = 1'b0;
                    SSR_OP_IDLE: oe_nxt = 1'b0;
                    default: oe_nxt = 1'b0;
                endcase
            end

            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    q_r <= DATA_RST;
                    oe_r <= 1'b0;
                end
                else
                begin
                    q_r <= q_nxt;
                    oe_r <= oe_nxt;
                end
            end

            assign rd_data = q_r;
            assign rd_data_oe = oe_r;

            pipe_data_a: assert property (@(posedge ref_clk)
                disable iff (!rst_n)
                (op == SSR_OP_READ) |=> (rd_data == $past(arr_word)))
                else $error("pipelined data wrong");
            last_read_a: assert property (@(posedge ref_clk)
                disable iff (!rst_n)
                (op != SSR_OP_READ) |=> $stable(rd_data))
                else $error("data changed without a read");
            reg_float_a: assert property (@(posedge ref_clk)
                disable iff (!rst_n)
                (op != SSR_OP_READ) |=> !rd_data_oe)
                else $error("outputs driven outside a read");
            c_reg_b2b: cover property (@(posedge ref_clk) disable iff (!rst_n)
                (op == SSR_OP_READ) ##1 (op == SSR_OP_READ));
        end
    endgenerate

    // shared-path checks
    // the release edge itself still resets the input registers
    sel_decode_a: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        (rst_n && !sel_n && !wr_en_n) |=> (op == SSR_OP_WRITE))
        else $error("write not decoded");
    rd_decode_a: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        (rst_n && !sel_n && wr_en_n) |=> (op == SSR_OP_READ))
        else $error("read not decoded");
    capture_a: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        rst_n |=> (addr_r == $past(word_addr) && din_r == $past(wr_data)))
        else $error("input capture wrong");
    wr_rd_back_a: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        (op == SSR_OP_WRITE) ##1
        (op == SSR_OP_READ && addr_r == $past(addr_r))
        |-> (arr_word == $past(din_r)))
        else $error("written word not read back");
    c_write: cover property (@(posedge ref_clk) disable iff (!rst_n)
        op == SSR_OP_WRITE);
    c_wr_then_rd: cover property (@(posedge ref_clk) disable iff (!rst_n)
        (op == SSR_OP_WRITE) ##1 (op == SSR_OP_READ));
endmodule : ssr_sram
`default_nettype wire

// ---- include/ssr_pkg.sv ----
/*
 * ssr_pkg: shared constants for the synchronous 16K x 4 static RAM.
 * Assumes nothing of its surroundings; imported by ssr_sram and the dv files.
 */
package ssr_pkg;
    localparam int ADDR_W = 14; // word address width
    localparam int DATA_W = 4; // word width
    localparam int WORDS = 16384; // array depth
    localparam logic OUT_LATCH = 1'b0; // transparent output stage
    localparam logic OUT_REG = 1'b1; // pipelined output stage
    localparam logic [3:0] DATA_RST = 4'h0; // reset value of data flops
    // operation of a cycle, from sampled select and write enable
    typedef enum logic [1:0] {
        SSR_OP_IDLE = 2'b00,
        SSR_OP_READ = 2'b01,
        SSR_OP_WRITE = 2'b10
    } ssr_op_t;
endpackage : ssr_pkg

// ---- design/ssr_array.sv ----
/*
 * ssr_array: flip-flop storage of the RAM with a write port clocked by ref_clk
 * and an asynchronous read port.
 * Assumes the caller presents registered address, data and write strobe.
 */
`timescale 1ns/1ns
`default_nettype none
module ssr_array #(
    parameter int ADDR_W = 14,
    parameter int DATA_W = 4
) (
    // clock
    input wire logic ref_clk,
    // write port
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_word,
    // read port
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_word
);
    localparam int DEPTH = 1 << ADDR_W;
    logic [DATA_W-1:0] mem_r [DEPTH];

    // array write on the clock edge after capture, gated by the wr_en strobe
    always_ff @(posedge ref_clk)
    begin
        if (wr_en)
        begin
            mem_r[wr_addr] <= wr_word;
        end
    end

    // read of the currently registered address
    assign rd_word = mem_r[rd_addr];
endmodule : ssr_array
`default_nettype wire

// ---- dv/ssr_ctl_model.sv ----
/* ssr_ctl_model: controller end of the read bus, captures at rise.
   Assumes rd_data is qualified by rd_data_oe. */
`timescale 1ns/1ns
`default_nettype none
module ssr_ctl_model (
    // clock
    input wire logic ref_clk,
    // read bus from the memory
    input wire logic [ssr_pkg::DATA_W-1:0] rd_data,
    input wire logic rd_data_oe,
    // captured word
    output logic [ssr_pkg::DATA_W-1:0] cap_data,
    output logic cap_oe
);
    import ssr_pkg::*;

    logic [ssr_pkg::DATA_W-1:0] last_r = '0;
    logic [ssr_pkg::DATA_W-1:0] bus;
    // a floating bus shows the inverse of the last driven word
    assign bus = rd_data_oe ? rd_data : ~last_r;
    // capture at the rising edge that closes the access
    always_ff @(posedge ref_clk)
    begin
        if (rd_data_oe)
            last_r <= rd_data;
        cap_data <= bus;
        cap_oe <= rd_data_oe;
    end
endmodule : ssr_ctl_model
`default_nettype wire

// ---- dv/tb_top.sv ----
/* tb_top: one access stream into both output variants, checked
   against a hand table. Assumes ssr_pkg and the model come first. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import ssr_pkg::*;
    typedef struct packed {
        logic s;
        logic w;
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
        logic eo;
        logic [DATA_W-1:0] ed;
    } ssr_row_t;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] word_addr = '0;
    logic [DATA_W-1:0] wr_data = '0;
    logic wr_en_n = 1'b1;
    logic sel_n = 1'b1;
    logic [DATA_W-1:0] lat_q, reg_q, cap_q;
    logic lat_oe, reg_oe, cap_oe;
    logic [DATA_W:0] held;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    ssr_row_t rows [10];
    ssr_row_t p;
    // both stages share the same inputs
    ssr_sram #(.OUT_MODE(OUT_LATCH)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .word_addr(word_addr), .wr_data(wr_data), .wr_en_n(wr_en_n),
        .sel_n(sel_n), .rd_data(lat_q), .rd_data_oe(lat_oe));
    ssr_sram #(.OUT_MODE(OUT_REG)) dut_reg (.ref_clk(ref_clk), .rst_n(rst_n),
        .word_addr(word_addr), .wr_data(wr_data), .wr_en_n(wr_en_n),
        .sel_n(sel_n), .rd_data(reg_q), .rd_data_oe(reg_oe));
    ssr_ctl_model ctl (.ref_clk(ref_clk), .rd_data(lat_q),
        .rd_data_oe(lat_oe), .cap_data(cap_q), .cap_oe(cap_oe));
    // clock
    initial
    begin
        forever #25 ref_clk = ~ref_clk;
    end
    // compare one value
    task automatic check(input logic [DATA_W:0] seen,
        input logic [DATA_W:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    // hang guard
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 200)
        begin
            n_errors++;
            tally_and_finish();
        end
    end
    // main sequence
    initial
    begin
        // row 8 reads so that the mid-run reset meets driven outputs
        rows = '{
            {2'b00, 14'h0000, 4'h5, 5'h00}, {2'b00, 14'h3FFF, 4'hA, 5'h00},
            {2'b01, 14'h0000, 4'h0, 5'h15}, {2'b01, 14'h3FFF, 4'h0, 5'h1A},
            {2'b10, 14'h0000, 4'hF, 5'h00}, {2'b01, 14'h0000, 4'h0, 5'h15},
            {2'b00, 14'h0001, 4'h3, 5'h00}, {2'b01, 14'h0001, 4'h0, 5'h13},
            {2'b01, 14'h0001, 4'h0, 5'h13}, {2'b11, 14'h0000, 4'h0, 5'h00}};
        repeat (12) @(posedge ref_clk);
        check({lat_oe, lat_q}, {1'b0, DATA_RST});
        check({reg_oe, reg_q}, {1'b0, DATA_RST});
        rst_n <= 1'b1;
        #26;
        held = {lat_oe, lat_q};
        // table: result of row i-2 is checked in cycle i
        for (int i = 0; i < 10; i++)
        begin
            @(posedge ref_clk);
            sel_n <= rows[i].s;
            wr_en_n <= rows[i].w;
            word_addr <= rows[i].a;
            wr_data <= rows[i].d;
            #1;
            if (i >= 2)
            begin
                p = rows[i-2];
                check({cap_oe, p.eo ? cap_q : p.ed},
                    {p.eo, p.ed});
                check({reg_oe, p.eo ? reg_q : p.ed},
                    {p.eo, p.ed});
            end
            // high phase still shows the value of the last low phase
            #22;
            check({lat_oe, lat_q}, held);
            #3;
            held = {lat_oe, lat_q};
        end
        // reset in mid-run, while the read of row 8 drives both stages
        @(posedge ref_clk);
        rst_n <= 1'b0;
        sel_n <= 1'b1;
        wr_en_n <= 1'b1;
        word_addr <= 14'h0000;
        #1;
        check({lat_oe, lat_q}, {1'b0, DATA_RST});
        check({reg_oe, reg_q}, {1'b0, DATA_RST});
        // release with a read that the first edge after it takes
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        sel_n <= 1'b0;
        @(posedge ref_clk);
        #30;
        check({lat_oe, lat_q}, 5'h15);
        @(posedge ref_clk);
        #1;
        check({reg_oe, reg_q}, 5'h15);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
